// ===== core/dase_encoder.v
// data abort syndrome encoder: low nine syndrome bits plus a small register port
//
// Functional notes
// - cache flag set for cache maintenance or synchronous translation-instruction faults, else cleared
// - zero, tag and tag-zero by address operations never set the cache flag
// - walk flag set for stage 2 fault on a stage 1 table walk access
// - walk flag reads zero for every abort that is not stage 2
// - write flag one for writing instructions, zero for reading ones
// - write flag forced to one for cache maintenance and translation instructions
// - atomic read-write: zero when a read would fault, else one
// - optional: atomic stage 2 walk aborts may report write flag zero
// - write flag unconstrained for external atomic aborts and unsupported-atomic codes
// - syndrome contents after warm reset are don't care until next abort
// - address size faults coded by level, level zero or table base all zero
// - translation faults coded 0x04 plus level zero to three
// - access flag faults 0x09 to 0x0b, level zero only with large addresses
// - permission faults 0x0d to 0x0f, level zero 0x0c with large addresses
// - external walk aborts 0x14 to 0x17, minus one 0x13, else 0x10
// - tag check fault 0x11 only with memory tagging
// - parity errors only without reliability feature, 0x18, 0x1c to 0x1f, 0x1b
// - alignment 0x21, granule walk level zero 0x24, minus one 0x23
// - feature-bound codes produced only when that feature is present
// - undefined status code values are never produced
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
`include "dase_map.vh"

module dase_encoder #(
    parameter       ADDR_W                = 8,
    parameter       DATA_W                = 32,
    parameter [0:0] LARGE_ADDRESS_FEATURE = 1'b1,
    parameter [0:0] MEMORY_TAGGING_FEATURE = 1'b1,
    parameter [0:0] RELIABILITY_FEATURE   = 1'b0,
    parameter [0:0] REALM_FEATURE         = 1'b1
) (
    // clock and reset
    input  wire              sys_clk,
    input  wire              sys_rst,
    // abort event from the translation pipeline
    input  wire              abort_take,
    input  wire [3:0]        fault_class,
    input  wire [2:0]        fault_level,
    input  wire              fault_on_walk,
    input  wire              acc_is_cmo,
    input  wire              acc_is_at,
    input  wire              zero_by_va_op,
    input  wire              tag_by_va_op,
    input  wire              tag_zero_by_va_op,
    input  wire              acc_is_stage2,
    input  wire              acc_s1_walk,
    input  wire              acc_is_write,
    input  wire              acc_is_atomic,
    input  wire              atomic_read_faults,
    // captured syndrome
    output reg               cache_maint_flag,
    output reg               stage1_walk_flag,
    output reg               write_not_read,
    output reg  [5:0]        fault_status_code,
    output reg               syndrome_valid,
    output reg               abort_rejected,
    // register port
    input  wire [ADDR_W-1:0] reg_addr,
    input  wire [DATA_W-1:0] reg_wdata,
    input  wire              reg_wr,
    input  wire              reg_rd,
    output reg  [DATA_W-1:0] reg_rdata
);

    // ============================================================
    // control and status storage
    reg  [1:0]  ctrl;
    reg         reject_seen;
    wire        relax_write;
    wire        capture_en;

    assign relax_write = ctrl[`DASE_CTRL_RELAX];
    assign capture_en = ctrl[`DASE_CTRL_CAPEN];

    // ============================================================
    // status code encoder
    reg  [5:0]  next_fsc;
    reg         code_ok;
    wire [5:0]  lvl_bits;
    wire        lvl_m1;
    wire        lvl_std;
    wire        lvl_zero;

    assign lvl_bits = {4'h0, fault_level[1:0]};
    assign lvl_m1   = (fault_level == `DASE_LVL_M1);
    assign lvl_std  = (fault_level <= `DASE_LVL_3);
    assign lvl_zero = (fault_level == `DASE_LVL_0);

    // a combination with no defined code is refused, never encoded
    always @* begin
        next_fsc = `DASE_FSC_RESET;
        code_ok  = 1'b0;
        case (fault_class)
            `DASE_CLS_ADDR_SIZE: begin
                next_fsc = `DASE_FSC_ADDR_SIZE | lvl_bits;
                code_ok  = lvl_std;
            end
            `DASE_CLS_TRANSLATE: begin
                next_fsc = `DASE_FSC_TRANSLATE | lvl_bits;
                code_ok  = lvl_std;
            end
            `DASE_CLS_ACCESS_FLAG: begin
                next_fsc = `DASE_FSC_ACCESS_FLAG | lvl_bits;
                code_ok  = lvl_std & (~lvl_zero | LARGE_ADDRESS_FEATURE);
            end
            `DASE_CLS_PERMISSION: begin
                next_fsc = `DASE_FSC_PERMISSION | lvl_bits;
                code_ok  = lvl_std & (~lvl_zero | LARGE_ADDRESS_FEATURE);
            end
            `DASE_CLS_EXT_ABORT: begin
                if (!fault_on_walk) begin
                    next_fsc = `DASE_FSC_EXT_NOWALK;
                    code_ok  = 1'b1;
                end else if (lvl_m1) begin
                    next_fsc = `DASE_FSC_EXT_WALK_M1;
                    code_ok  = LARGE_ADDRESS_FEATURE;
                end else begin
                    next_fsc = `DASE_FSC_EXT_WALK | lvl_bits;
                    code_ok  = lvl_std;
                end
            end
            `DASE_CLS_TAG_CHECK: begin
                next_fsc = `DASE_FSC_TAG_CHECK;
                code_ok  = MEMORY_TAGGING_FEATURE;
            end
            `DASE_CLS_PARITY: begin
                if (!fault_on_walk) begin
                    next_fsc = `DASE_FSC_PAR_NOWALK;
                    code_ok  = ~RELIABILITY_FEATURE;
                end else if (lvl_m1) begin
                    next_fsc = `DASE_FSC_PAR_WALK_M1;
                    code_ok  = ~RELIABILITY_FEATURE & LARGE_ADDRESS_FEATURE;
                end else begin
                    next_fsc = `DASE_FSC_PAR_WALK | lvl_bits;
                    code_ok  = ~RELIABILITY_FEATURE & lvl_std;
                end
            end
            `DASE_CLS_ALIGNMENT: begin
                next_fsc = `DASE_FSC_ALIGNMENT;
                code_ok  = 1'b1;
            end
            `DASE_CLS_GRANULE: begin
                // granule walk at level zero or minus one
                if (lvl_m1) begin
                    next_fsc = `DASE_FSC_GPF_WALK_M1;
                    code_ok  = REALM_FEATURE & LARGE_ADDRESS_FEATURE & fault_on_walk;
                end else begin
                    next_fsc = `DASE_FSC_GPF_WALK_L0;
                    code_ok  = REALM_FEATURE & lvl_zero & fault_on_walk;
                end
            end
            default: begin
                next_fsc = `DASE_FSC_RESET;
                code_ok  = 1'b0;
            end
        endcase
    end

    // ============================================================
    // flag encoder
    reg         next_cache;
    reg         next_s1;
    reg         next_write;
    wire        tag_zero_ops;
    wire        is_maint_class;
    wire        s2_on_walk;

    // the three zeroing and tagging operations are plain stores here
    assign tag_zero_ops   = zero_by_va_op | tag_by_va_op | tag_zero_by_va_op;
    assign is_maint_class = (acc_is_cmo & ~tag_zero_ops) | acc_is_at;
    assign s2_on_walk     = acc_is_stage2 & acc_s1_walk;

    always @* begin
        next_cache = is_maint_class;
        next_s1 = s2_on_walk;
        next_write = acc_is_write;
        if (is_maint_class) begin
            next_write = 1'b1;
        end else if (acc_is_atomic) begin
            // external atomic falls through to the same rule
            next_write = ~atomic_read_faults;
            if (relax_write && s2_on_walk) begin
                next_write = 1'b0;
            end
        end
    end

    // ============================================================
    // syndrome capture
    wire        capture;
    wire        refuse;

    assign capture = abort_take & code_ok & capture_en;
    assign refuse  = abort_take & ~capture;

    // reset value is a convenience, software must not rely on it
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cache_maint_flag  <= 1'b0;
            stage1_walk_flag  <= 1'b0;
            write_not_read    <= 1'b0;
            fault_status_code <= `DASE_FSC_RESET;
        end else if (capture) begin
            cache_maint_flag  <= next_cache;
            stage1_walk_flag  <= next_s1;
            write_not_read    <= next_write;
            fault_status_code <= next_fsc;
        end
    end

    // ============================================================
    // sticky status and one-cycle refusal pulse, an event in the clear cycle wins
    wire        wr_stat;
    wire        wr_ctrl;

    assign wr_stat = reg_wr & (reg_addr == `DASE_OFS_STAT);
    assign wr_ctrl = reg_wr & (reg_addr == `DASE_OFS_CTRL);

    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            syndrome_valid <= 1'b0;
            reject_seen    <= 1'b0;
            abort_rejected <= 1'b0;
        end else begin
            abort_rejected <= refuse;
            if (capture) begin
                syndrome_valid <= 1'b1;
            end else if (wr_stat && reg_wdata[`DASE_STAT_VALID]) begin
                syndrome_valid <= 1'b0;
            end
            if (refuse) begin
                reject_seen <= 1'b1;
            end else if (wr_stat && reg_wdata[`DASE_STAT_REJECT]) begin
                reject_seen <= 1'b0;
            end
        end
    end

    // ============================================================
    // control register
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl <= `DASE_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl <= reg_wdata[`DASE_CTRL_CAPEN:`DASE_CTRL_RELAX];
        end
    end

    // ============================================================
    // read port, data stand one cycle after the strobe only
    reg  [DATA_W-1:0] next_rdata;

    always @* begin
        next_rdata = `DASE_DATA_ZERO;
        if (reg_rd) begin
            case (reg_addr)
                `DASE_OFS_SYND: begin
                    next_rdata[`DASE_SYN_CACHE_BIT] = cache_maint_flag;
                    next_rdata[`DASE_SYN_S1_BIT]    = stage1_walk_flag;
                    next_rdata[`DASE_SYN_WRITE_BIT] = write_not_read;
                    next_rdata[`DASE_SYN_FSC_HI:`DASE_SYN_FSC_LO] = fault_status_code;
                end
                `DASE_OFS_STAT: begin
                    next_rdata[`DASE_STAT_VALID]  = syndrome_valid;
                    next_rdata[`DASE_STAT_REJECT] = reject_seen;
                end
                `DASE_OFS_CTRL: begin
                    next_rdata[`DASE_CTRL_CAPEN:`DASE_CTRL_RELAX] = ctrl;
                end
                default: begin
                    // unmapped reads return zero
                    next_rdata = `DASE_DATA_ZERO;
                end
            endcase
        end
    end

    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= `DASE_DATA_ZERO;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

endmodule

// ===== core/dase_map.vh
// register map, field layout and fault code constants of the abort syndrome encoder
`ifndef DASE_MAP_VH
`define DASE_MAP_VH

// ============================================================
// fault classes presented by the pipeline
`define DASE_CLS_ADDR_SIZE   4'h0
`define DASE_CLS_TRANSLATE   4'h1
`define DASE_CLS_ACCESS_FLAG 4'h2
`define DASE_CLS_PERMISSION  4'h3
`define DASE_CLS_EXT_ABORT   4'h4
`define DASE_CLS_TAG_CHECK   4'h5
`define DASE_CLS_PARITY      4'h6
`define DASE_CLS_ALIGNMENT   4'h7
`define DASE_CLS_GRANULE     4'h8

// ============================================================
// lookup level encoding, minus one is all ones
`define DASE_LVL_M1 3'h7
`define DASE_LVL_0  3'h0
`define DASE_LVL_1  3'h1
`define DASE_LVL_3  3'h3

// ============================================================
// status code bases, level is or-ed into the low two bits
`define DASE_FSC_ADDR_SIZE   6'h00
`define DASE_FSC_TRANSLATE   6'h04
`define DASE_FSC_ACCESS_FLAG 6'h08
`define DASE_FSC_PERMISSION  6'h0c
`define DASE_FSC_EXT_NOWALK  6'h10
`define DASE_FSC_TAG_CHECK   6'h11
`define DASE_FSC_EXT_WALK_M1 6'h13
`define DASE_FSC_EXT_WALK    6'h14
`define DASE_FSC_PAR_NOWALK  6'h18
`define DASE_FSC_PAR_WALK_M1 6'h1b
`define DASE_FSC_PAR_WALK    6'h1c
`define DASE_FSC_ALIGNMENT   6'h21
`define DASE_FSC_GPF_WALK_M1 6'h23
`define DASE_FSC_GPF_WALK_L0 6'h24
`define DASE_FSC_RESET       6'h00

// ============================================================
// register offsets
`define DASE_OFS_SYND 8'h00
`define DASE_OFS_STAT 8'h04
`define DASE_OFS_CTRL 8'h08

// ============================================================
// field positions
`define DASE_SYN_CACHE_BIT 8
`define DASE_SYN_S1_BIT    7
`define DASE_SYN_WRITE_BIT 6
`define DASE_SYN_FSC_HI    5
`define DASE_SYN_FSC_LO    0
`define DASE_STAT_VALID    0
`define DASE_STAT_REJECT   1
`define DASE_CTRL_RELAX    0
`define DASE_CTRL_CAPEN    1
`define DASE_CTRL_RESET    2'h2
`define DASE_DATA_ZERO     32'h00000000

`endif

// ===== verif/dase_encoder_asserts.sv
// concurrent checks on the abort syndrome encoder ports
`timescale 1ns/1ps
module dase_encoder_chk (
    // clock and reset
    input wire       sys_clk,
    input wire       sys_rst,
    // abort event
    input wire       abort_take,
    input wire [3:0] fault_class,
    input wire [2:0] fault_level,
    input wire       fault_on_walk,
    input wire       acc_is_cmo,
    input wire       acc_is_at,
    input wire       zero_by_va_op,
    input wire       tag_by_va_op,
    input wire       tag_zero_by_va_op,
    input wire       acc_is_stage2,
    input wire       acc_s1_walk,
    input wire       acc_is_write,
    input wire       acc_is_atomic,
    // syndrome
    input wire       cache_maint_flag,
    input wire       stage1_walk_flag,
    input wire       write_not_read,
    input wire [5:0] fault_status_code,
    input wire       abort_rejected
);
    wire cmo_hit = (acc_is_cmo & ~(zero_by_va_op | tag_by_va_op | tag_zero_by_va_op)) | acc_is_at;
    wire [8:0] syn = {cache_maint_flag, stage1_walk_flag, write_not_read, fault_status_code};
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // ============================================================
    // abort steps
    sequence s_taken;
        abort_take ##1 !abort_rejected;
    endsequence
    sequence s_refused;
        abort_take ##1 abort_rejected;
    endsequence
    // ============================================================
    // flags and codes
    chk_cache_flag: assert property (s_taken |-> cache_maint_flag == $past(cmo_hit))
        else $error("cache flag wrong");
    chk_walk_flag: assert property (s_taken |-> stage1_walk_flag == $past(acc_is_stage2 & acc_s1_walk))
        else $error("walk flag wrong");
    chk_walk_zero: assert property (abort_take && !acc_is_stage2 ##1 !abort_rejected |-> !stage1_walk_flag)
        else $error("walk flag set off stage 2");
    chk_write_maint: assert property (abort_take && cmo_hit ##1 !abort_rejected |-> write_not_read)
        else $error("write flag low on maintenance");
    chk_write_plain: assert property (abort_take && !cmo_hit && !acc_is_atomic
        ##1 !abort_rejected |-> write_not_read == $past(acc_is_write))
        else $error("write flag wrong");
    chk_trans_code: assert property (abort_take && fault_class == 4'h1 && fault_level < 3'h4 ##1 !abort_rejected
        |-> fault_status_code == {4'h1, $past(fault_level[1:0])})
        else $error("translation code wrong");
    chk_ext_walk: assert property (abort_take && fault_class == 4'h4 && fault_on_walk
        && fault_level < 3'h4 ##1 !abort_rejected |-> fault_status_code == {4'h5, $past(fault_level[1:0])})
        else $error("external walk code wrong");
    chk_gpf_code: assert property (abort_take && fault_class == 4'h8 && fault_on_walk && fault_level == 3'h0
        ##1 !abort_rejected |-> fault_status_code == 6'h24)
        else $error("granule code wrong");
    chk_undef_refused: assert property (abort_take && fault_class > 4'h8 |=> abort_rejected)
        else $error("reserved class accepted");
    chk_code_legal: assert property (fault_status_code inside {[6'h00:6'h11], [6'h13:6'h18],
        [6'h1b:6'h1f], 6'h21, 6'h23, 6'h24})
        else $error("undefined status code");
    chk_refused_hold: assert property (s_refused |-> $stable(syn))
        else $error("refused abort changed syndrome");
    chk_syn_quiet: assert property (!$stable(syn) |-> $past(abort_take))
        else $error("syndrome changed without abort");
endmodule

bind dase_encoder dase_encoder_chk i_chk (.sys_clk, .sys_rst, .abort_take, .fault_class, .fault_level,
    .fault_on_walk, .acc_is_cmo, .acc_is_at, .zero_by_va_op, .tag_by_va_op, .tag_zero_by_va_op,
    .acc_is_stage2, .acc_s1_walk, .acc_is_write, .acc_is_atomic, .cache_maint_flag, .stage1_walk_flag,
    .write_not_read, .fault_status_code, .abort_rejected);

// ===== verif/tb_top.sv
// self-checking bench of the abort syndrome encoder
`timescale 1ns/1ps
`include "dase_map.vh"
module tb_top;
    // ============================================================
    // stimulus and observed signals
    reg         sys_clk = 1'b0;
    reg         sys_rst = 1'b1;
    reg         abort_take = 1'b0;
    reg  [3:0]  fault_class = 4'h0;
    reg  [2:0]  fault_level = 3'h0;
    reg  [10:0] fl = 11'h000;
    reg  [7:0]  reg_addr = 8'h00;
    reg  [31:0] reg_wdata = 32'h00000000;
    reg         reg_wr = 1'b0;
    reg         reg_rd = 1'b0;
    wire        cache_maint_flag;
    wire        stage1_walk_flag;
    wire        write_not_read;
    wire [5:0]  fault_status_code;
    wire        syndrome_valid;
    wire        abort_rejected;
    wire [31:0] reg_rdata;
    wire [8:0]  obs_syn = {cache_maint_flag, stage1_walk_flag, write_not_read, fault_status_code};
    reg  [8:0]  e_syn = 9'h000;
    reg         e_val = 1'b0;
    reg         e_rej = 1'b0;
    reg         relax = 1'b0;
    reg         capen = 1'b1;
    reg  [3:0]  rc;
    reg  [2:0]  rl;
    reg  [10:0] rf;
    integer     n_mismatch = 0;
    integer     n_tests = 0;
    integer     cyc = 0;
    integer     i;
    always #2.5 sys_clk = ~sys_clk;
    dase_encoder i_dut (
        .sys_clk, .sys_rst, .abort_take, .fault_class, .fault_level,
        .fault_on_walk(fl[10]), .acc_is_cmo(fl[9]), .acc_is_at(fl[8]), .zero_by_va_op(fl[7]),
        .tag_by_va_op(fl[6]), .tag_zero_by_va_op(fl[5]), .acc_is_stage2(fl[4]), .acc_s1_walk(fl[3]),
        .acc_is_write(fl[2]), .acc_is_atomic(fl[1]), .atomic_read_faults(fl[0]),
        .cache_maint_flag, .stage1_walk_flag, .write_not_read, .fault_status_code,
        .syndrome_valid, .abort_rejected, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata
    );
    // ============================================================
    // expected code with accept bit on top; levels limited to 0..3 and 7
    function [6:0] exp_code(input [3:0] c, input [2:0] l, input w);
        begin
            exp_code = 7'h00;
            case (c)
                4'h0, 4'h1, 4'h2, 4'h3: exp_code = (l == 3'h7) ? 7'h00 : {3'b100, c[1:0], l[1:0]};
                4'h4: exp_code = w ? ((l == 3'h7) ? 7'h53 : {5'h15, l[1:0]}) : 7'h50;
                4'h5: exp_code = 7'h51;
                4'h6: exp_code = w ? ((l == 3'h7) ? 7'h5b : {5'h17, l[1:0]}) : 7'h58;
                4'h7: exp_code = 7'h61;
                4'h8: exp_code = !w ? 7'h00 : (l == 3'h0) ? 7'h64 : (l == 3'h7) ? 7'h63 : 7'h00;
                default: exp_code = 7'h00;
            endcase
        end
    endfunction
    task check(input [31:0] seen, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task test_done;
        begin
            $display("checks %0d mismatches %0d", n_tests, n_mismatch);
            if (n_mismatch == 0 && n_tests > 0) begin
                $display("ALL TESTS PASSED");
            end else begin
                $display("TESTS FAILED");
            end
            $finish;
        end
    endtask
    // ============================================================
    // bus and abort drivers
    task reg_write(input [7:0] a, input [31:0] d);
        begin
            @(posedge sys_clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge sys_clk);
            reg_wr <= 1'b0;
            if (a == `DASE_OFS_CTRL) begin
                capen = d[1];
                relax = d[0];
            end
            if (a == `DASE_OFS_STAT) begin
                e_val = e_val & ~d[0];
                e_rej = e_rej & ~d[1];
            end
        end
    endtask
    task reg_read(input [7:0] a, input [31:0] e);
        begin
            @(posedge sys_clk);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge sys_clk);
            reg_rd <= 1'b0;
            #1;
            check(reg_rdata, e);
            // read data stand one cycle only, then fall back to zero
            @(posedge sys_clk);
            #1;
            check(reg_rdata, 32'h00000000);
        end
    endtask
    task abort_go(input [3:0] c, input [2:0] l, input [10:0] f);
        reg [6:0] k;
        reg       m;
        begin
            k = exp_code(c, l, f[10]);
            m = (f[9] & ~|f[7:5]) | f[8];
            @(posedge sys_clk);
            abort_take <= 1'b1;
            fault_class <= c;
            fault_level <= l;
            fl <= f;
            @(posedge sys_clk);
            abort_take <= 1'b0;
            if (k[6] && capen) begin
                e_syn = {m, f[4] & f[3], m | (f[1] ? ~f[0] & ~(relax & f[4] & f[3]) : f[2]), k[5:0]};
                e_val = 1'b1;
            end else begin
                e_rej = 1'b1;
            end
            #1;
            // flags and code
            check(obs_syn, e_syn);
            // refusal pulse and capture
            check({syndrome_valid, abort_rejected}, {e_val, ~(k[6] & capen)});
        end
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            test_done;
        end
    end
    // ============================================================
    // main sequence
    initial begin
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        i = $urandom(68);
        reg_read(`DASE_OFS_CTRL, 32'h00000002);
        reg_read(`DASE_OFS_STAT, 32'h00000000);
        reg_read(8'h0c, 32'h00000000);
        $display("test registers after reset done");
        abort_go(4'h1, 3'h2, 11'h000);
        abort_go(4'h8, 3'h0, 11'h400);
        abort_go(4'h8, 3'h7, 11'h400);
        abort_go(4'h8, 3'h0, 11'h000);
        abort_go(4'h9, 3'h0, 11'h000);
        abort_go(4'h0, 3'h7, 11'h000);
        abort_go(4'h6, 3'h7, 11'h400);
        abort_go(4'h3, 3'h1, 11'h284);
        abort_go(4'h2, 3'h0, 11'h103);
        reg_write(`DASE_OFS_SYND, 32'hffffffff);
        reg_read(`DASE_OFS_SYND, {23'h000000, e_syn});
        $display("test corner codes done");
        reg_write(`DASE_OFS_CTRL, 32'h00000000);
        abort_go(4'h1, 3'h1, 11'h000);
        reg_read(`DASE_OFS_STAT, {30'h0, e_rej, e_val});
        reg_write(`DASE_OFS_CTRL, 32'h00000003);
        abort_go(4'h3, 3'h1, 11'h01a);
        reg_write(`DASE_OFS_STAT, 32'h00000003);
        reg_read(`DASE_OFS_STAT, 32'h00000000);
        reg_write(`DASE_OFS_CTRL, 32'h00000002);
        $display("test capture control done");
        for (i = 0; i < 300; i = i + 1) begin
            rc = $urandom_range(15);
            rl = $urandom_range(4);
            rf = $urandom;
            if (rl == 3'h4) rl = 3'h7;
            // external and parity aborts off a walk are held at level zero in random traffic
            if (rc[3:2] == 2'b01 && !rc[0] && !rf[10]) rl = 3'h0;
            // zero and tag ops are plain writes, so the write flag is the same either way
            if (|rf[7:5]) rf[2:0] = 3'b100;
            abort_go(rc, rl, rf);
            if (i % 50 == 49) begin
                reg_read(`DASE_OFS_SYND, {23'h000000, e_syn});
                reg_write(`DASE_OFS_CTRL, {30'h0, 1'b1, ~relax});
            end
        end
        $display("test random aborts done");
        test_done;
    end
endmodule
